//--- hdl/pdl_station.v
// Polled multi-drop data link station, master or slave by configuration.
// Assumes a link engine outside that frames words and reports each
// attempt's result on linkDone with its error bits.
// Function
// - Word count per direction configurable, zero to six
// - Master reserves six transmit, six receive words
// - Master serves up to thirty-one slaves
// - Blocks stride twelve; slaves use fixed local blocks
// - Ports two/three write codes to configured register
// - Any exchange error on port one sets the link error flag
// - Link error flag sticky until cleared or reset
// - Link error flag inactive on ports two/three
// - Prohibit flag stops master from issuing exchanges
// - Clearing prohibit resumes master exchanges
// - Prohibit flag retained, held until host clears
// - Prohibited master makes slaves raise stop flag
// - Master has 31 error codes, slave one
// - Two retries; third failure records code, separate clears
// - Error codes bit-coded and ORed together
// - Slave stop flag after ten silent seconds
`include "pdl_map.vh"

module pdl_station #(
  parameter integer STOP_CYCLES = `PDL_STOP_CYCLES
) (
  input  wire                   clk_sys,
  input  wire                   reset,
  input  wire                   cfgMaster,
  input  wire [1:0]             cfgPort,
  input  wire [2:0]             cfgWordCount,
  input  wire [4:0]             cfgSlaveCount,
  input  wire [4:0]             cfgStationNo,
  input  wire [8:0]             cfgAltErrIndex,
  input  wire                   prohibitRetained,
  input  wire                   prohibitSet,
  input  wire                   prohibitClear,
  input  wire                   stickyClear,
  input  wire                   errClear,
  input  wire [4:0]             errAddr,
  output reg  [6:0]             errRdata,
  input  wire [8:0]             hostAddr,
  input  wire                   hostWrite,
  input  wire [`PDL_WORD_W-1:0] hostWdata,
  output reg  [`PDL_WORD_W-1:0] hostRdata,
  output reg                    txValid,
  input  wire                   txReady,
  output reg  [`PDL_WORD_W-1:0] txData,
  output reg                    txLast,
  input  wire                   rxValid,
  output wire                   rxReady,
  input  wire [`PDL_WORD_W-1:0] rxData,
  input  wire                   linkDone,
  input  wire [4:0]             linkErr,
  output reg  [4:0]             pollStation,
  output reg                    linkErrorStickyFlag,
  output reg                    linkProhibitFlag,
  output reg                    linkInitOrStopFlag
);

  localparam [3:0] ST_IDLE = 4'h1;
  localparam [3:0] ST_SEND = 4'h2;
  localparam [3:0] ST_RECV = 4'h4;
  localparam [3:0] ST_DONE = 4'h8;

  // Word index of one word of a station's block
  function [8:0] blockIndex;
    input [4:0] station;
    input       isRx;
    input [2:0] word;
    reg   [8:0] base;
    begin
      base       = {4'h0, station} - 9'h001;
      blockIndex = base * `PDL_BLOCK_STRIDE
                   + (isRx ? `PDL_RX_OFFSET : 9'h000) + {6'h00, word};
    end
  endfunction

  reg [`PDL_WORD_W-1:0] dataMem [0:`PDL_DATA_DEPTH-1];
  reg [6:0]             errMem  [0:30];
  reg [`PDL_WORD_W-1:0] shadow  [0:5];
  reg [3:0]             state;
  reg [2:0]             txBeat;
  reg [2:0]             rxCount;
  reg [1:0]             retryCount;
  reg [28:0]            stopCount;
  integer               i;

  wire [`PDL_WORD_W-1:0] bufData;
  wire                   bufValid;
  wire                   bufReady = state[2] & (rxCount < `PDL_WORDS_MAX);
  wire                   bufPop   = bufValid & bufReady;

  pdl_two_buffer rxBuffer (
    .clk_sys  (clk_sys),
    .reset    (reset),
    .inValid  (rxValid),
    .inReady  (rxReady),
    .inData   (rxData),
    .outValid (bufValid),
    .outReady (bufReady),
    .outData  (bufData)
  );

  ////////////////////////////////////////////////////////////////////////
  // Attempt evaluation

  // Counts above six are treated as six
  wire [2:0] wordCount = (cfgWordCount > `PDL_WORDS_MAX) ?
                         `PDL_WORDS_MAX : cfgWordCount;
  wire [4:0] myStation = cfgMaster ? pollStation : 5'h01;
  wire       fixedPort = (cfgPort == `PDL_PORT_FIXED);
  wire       linkTake  = state[2] & linkDone;
  wire [6:0] attemptCode = {(rxCount != wordCount), 1'b0, linkErr};
  wire       attemptOk = (attemptCode == 7'h00);
  wire       retryLeft = (retryCount < `PDL_RETRIES);
  wire       recordErr = linkTake & ~attemptOk & ~retryLeft;
  wire [6:0] recordCode = attemptCode | `PDL_ERR_RETRY;
  wire [4:0] errSlot   = cfgMaster ? pollStation - 5'h01 : 5'h00;
  wire       commit    = linkTake & attemptOk;
  wire       lastPoll  = (pollStation >= cfgSlaveCount);

  task loadHeader;
    begin
      txValid <= 1'b1;
      txData  <= {11'h000, cfgMaster ? pollStation : cfgStationNo};
      txBeat  <= 3'h0;
      txLast  <= (wordCount == 3'h0);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Exchange sequencer

  always @(posedge clk_sys) begin
    if (reset) begin
      state       <= ST_IDLE;
      txValid     <= 1'b0;
      txData      <= 16'h0000;
      txLast      <= 1'b0;
      txBeat      <= 3'h0;
      rxCount     <= 3'h0;
      retryCount  <= 2'h0;
      pollStation <= 5'h01;
    end else begin
      if (bufPop) begin
        shadow[rxCount] <= bufData;
        rxCount         <= rxCount + 3'h1;
      end
      case (state)
        ST_IDLE: begin
          if (!cfgMaster) begin
            state   <= ST_RECV;
            rxCount <= 3'h0;
          end else if (!linkProhibitFlag &&
                       cfgSlaveCount != 5'h00) begin
            state <= ST_SEND;
            loadHeader;
          end
        end
        ST_SEND: begin
          if (txValid && txReady) begin
            if (txLast) begin
              txValid <= 1'b0;
              txLast  <= 1'b0;
              state   <= ST_RECV;
              rxCount <= 3'h0;
            end else begin
              // Beat n carries word n-1 of the transmit block
              txData <= dataMem[blockIndex(myStation, 1'b0, txBeat)];
              txBeat <= txBeat + 3'h1;
              txLast <= (txBeat + 3'h1 == wordCount);
            end
          end
        end
        ST_RECV: begin
          if (linkTake) begin
            if (attemptOk || !retryLeft)
              retryCount <= 2'h0;
            else
              retryCount <= retryCount + 2'h1;
            if (cfgMaster) begin
              if (attemptOk || !retryLeft) begin
                state <= ST_DONE;
              end else begin
                state <= ST_SEND;
                loadHeader;
              end
            end else if (attemptOk) begin
              state <= ST_SEND;
              loadHeader;
            end else begin
              rxCount <= 3'h0;
            end
          end
        end
        ST_DONE: begin
          // Only stations one to the configured count are polled
          pollStation <= lastPoll ? 5'h01 : pollStation + 5'h01;
          state       <= ST_IDLE;
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Data storage and host access

  // Exchange writes take the cycle; a host write in it is dropped
  always @(posedge clk_sys) begin
    if (commit) begin
      for (i = 0; i < 6; i = i + 1) begin
        if (i < wordCount)
          dataMem[blockIndex(myStation, 1'b1, i[2:0])] <= shadow[i];
      end
    end else if (recordErr && !fixedPort) begin
      dataMem[cfgAltErrIndex] <= {9'h000, recordCode};
    end else if (hostWrite && hostAddr < `PDL_DATA_DEPTH) begin
      dataMem[hostAddr] <= hostWdata;
    end
  end

  always @(posedge clk_sys) begin
    if (reset)
      hostRdata <= 16'h0000;
    else if (hostAddr < `PDL_DATA_DEPTH)
      hostRdata <= dataMem[hostAddr];
    else
      hostRdata <= 16'h0000;
  end

  ////////////////////////////////////////////////////////////////////////
  // Error codes and flags

  always @(posedge clk_sys) begin
    if (reset) begin
      for (i = 0; i < 31; i = i + 1)
        errMem[i] <= 7'h00;
      errRdata <= 7'h00;
    end else begin
      for (i = 0; i < 31; i = i + 1) begin
        // A new record wins over a clear in the same cycle
        if (recordErr && fixedPort && errSlot == i[4:0])
          errMem[i] <= errMem[i] | recordCode;
        else if (errClear && errAddr == i[4:0])
          errMem[i] <= 7'h00;
      end
      errRdata <= (errAddr < `PDL_SLAVES_MAX) ? errMem[errAddr] : 7'h00;
    end
  end

  always @(posedge clk_sys) begin
    if (reset) begin
      linkErrorStickyFlag <= 1'b0;
      // Retained value is reloaded here, not lost with power
      linkProhibitFlag    <= prohibitRetained;
      linkInitOrStopFlag  <= 1'b0;
      stopCount           <= 29'h00000000;
    end else begin
      if (linkTake && !attemptOk && fixedPort)
        linkErrorStickyFlag <= 1'b1;
      else if (stickyClear)
        linkErrorStickyFlag <= 1'b0;
      if (prohibitSet)
        linkProhibitFlag <= 1'b1;
      else if (prohibitClear)
        linkProhibitFlag <= 1'b0;
      if (cfgMaster || commit) begin
        stopCount          <= 29'h00000000;
        linkInitOrStopFlag <= 1'b0;
      end else if (stopCount >= STOP_CYCLES[28:0] - 29'h00000001) begin
        // A prohibited master stops polling, so silence trips this
        linkInitOrStopFlag <= 1'b1;
      end else begin
        stopCount <= stopCount + 29'h00000001;
      end
    end
  end

endmodule // pdl_station

//--- shared/pdl_map.vh
// Constants for the polled station data link block.
// Assumes word-indexed data storage and a 40 MHz system clock.
`ifndef PDL_MAP_VH
`define PDL_MAP_VH

`define PDL_WORD_W        16
`define PDL_WORDS_MAX     3'h6
`define PDL_SLAVES_MAX    5'h1f
`define PDL_BLOCK_STRIDE  9'h00c
`define PDL_RX_OFFSET     9'h006
`define PDL_DATA_DEPTH    372
`define PDL_RETRIES       2'h2
`define PDL_PORT_FIXED    2'h1

// Bit-coded error causes, ORed together
`define PDL_ERR_OVERRUN   7'h01
`define PDL_ERR_FRAMING   7'h02
`define PDL_ERR_PARITY    7'h04
`define PDL_ERR_TIMEOUT   7'h08
`define PDL_ERR_BLOCK     7'h10
`define PDL_ERR_RETRY     7'h20
`define PDL_ERR_MISMATCH  7'h40

// Silence time before a slave raises its stop flag
`define PDL_STOP_TIME_MS  10000
`define PDL_CLK_KHZ       40000
`define PDL_STOP_CYCLES   (`PDL_STOP_TIME_MS * `PDL_CLK_KHZ)

`endif

//--- hdl/pdl_two_buffer.v
// Two-entry buffer with valid/ready on both sides.
// Assumes one clock and a synchronous active-high reset.
`include "pdl_map.vh"

module pdl_two_buffer (
  input  wire                   clk_sys,
  input  wire                   reset,
  input  wire                   inValid,
  output reg                    inReady,
  input  wire [`PDL_WORD_W-1:0] inData,
  output reg                    outValid,
  input  wire                   outReady,
  output reg  [`PDL_WORD_W-1:0] outData
);

  reg [`PDL_WORD_W-1:0] second;
  reg [1:0]             count;
  reg [1:0]             next_count;
  wire                  push = inValid & inReady;
  wire                  pop  = outValid & outReady;

  always @* begin
    next_count = count;
    if (push & ~pop)
      next_count = count + 2'h1;
    else if (pop & ~push)
      next_count = count - 2'h1;
  end

  always @(posedge clk_sys) begin
    if (reset) begin
      count    <= 2'h0;
      outValid <= 1'b0;
      inReady  <= 1'b1;
      outData  <= 16'h0000;
      second   <= 16'h0000;
    end else begin
      count    <= next_count;
      outValid <= (next_count != 2'h0);
      // Ready from a flop, loaded from next_count: the source sees the stall in the cycle the buffer fills
      inReady  <= (next_count != 2'h2);
      if (pop & push) begin
        if (count == 2'h1) begin
          outData <= inData;
        end else begin
          outData <= second;
          second  <= inData;
        end
      end else if (pop) begin
        outData <= second;
      end else if (push) begin
        if (count == 2'h0)
          outData <= inData;
        else
          second <= inData;
      end
    end
  end

endmodule // pdl_two_buffer

//--- verif/pdl_link_peer.sv
// Behavioural far end of the link: takes each polled frame, answers
// with nWords receive words, then reports the attempt on linkDone.
`include "pdl_map.vh"
module pdl_link_peer (
  input  logic                   clk_sys,
  input  logic                   txValid,
  input  logic [`PDL_WORD_W-1:0] txData,
  input  logic                   txLast,
  output logic                   txReady,
  output logic                   rxValid,
  output logic [`PDL_WORD_W-1:0] rxData,
  input  logic                   rxReady,
  output logic                   linkDone,
  output logic [4:0]             linkErr,
  input  logic [2:0]             nWords,
  input  logic [4:0]             failBits,
  output logic [7:0]             doneCnt,
  output logic [4:0]             hdrSt,
  output logic [`PDL_WORD_W-1:0] txW0
);
  timeunit 1ns;
  timeprecision 1ps;
  int beat;
  initial begin
    {txReady, rxValid, linkDone, linkErr, doneCnt, hdrSt, txW0} = '0;
    rxData = 16'hffff;
    beat = 0;
    forever begin
      @(posedge clk_sys);
      // Slow taker: accepts a beat on every other cycle only
      txReady <= ~txReady;
      if (txValid && txReady) begin
        if (beat == 0) hdrSt <= txData[4:0];
        if (beat == 1) txW0 <= txData;
        beat = txLast ? 0 : beat + 1;
        if (txLast) begin
          for (int i = 0; i < nWords; i++) begin
            rxValid <= 1'b1;
            rxData <= {3'h5, hdrSt, 5'h00, 3'(i)};
            do @(posedge clk_sys); while (!rxReady);
          end
          rxValid <= 1'b0;
          // Released line shows the inverse, never a stale word
          rxData <= ~rxData;
          repeat (2) @(posedge clk_sys);
          linkDone <= 1'b1;
          linkErr <= failBits;
          @(posedge clk_sys);
          linkDone <= 1'b0;
          linkErr <= 5'h00;
          doneCnt <= doneCnt + 8'h01;
        end
      end
    end
  end
endmodule // pdl_link_peer

//--- verif/pdl_station_monitor.sv
// Checker for the station's flags, polling and transmit stream.
// Assumes it is bound to the station top with its own port names.
module pdl_station_monitor #(
  parameter integer STOP_CYCLES = 50
) (
  input logic        clk_sys,
  input logic        reset,
  input logic        cfgMaster,
  input logic [1:0]  cfgPort,
  input logic [4:0]  cfgSlaveCount,
  input logic        prohibitSet,
  input logic        prohibitClear,
  input logic        stickyClear,
  input logic [6:0]  errRdata,
  input logic        txValid,
  input logic        txReady,
  input logic [15:0] txData,
  input logic        txLast,
  input logic        linkDone,
  input logic [4:0]  linkErr,
  input logic [4:0]  pollStation,
  input logic        linkErrorStickyFlag,
  input logic        linkProhibitFlag,
  input logic        linkInitOrStopFlag
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  // A retry header follows linkDone within three cycles, hence the gap
  chk_quiet_prohibit: assert property (
    (linkProhibitFlag && !txValid && !linkDone)[*8] |=> !txValid)
    else $error("exchange began while prohibited");
  chk_prohibit_set: assert property (
    prohibitSet |=> linkProhibitFlag) else $error("prohibit not set");
  chk_prohibit_hold: assert property (
    linkProhibitFlag && !prohibitClear |=> linkProhibitFlag)
    else $error("prohibit dropped");
  chk_prohibit_clear: assert property (
    prohibitClear && !prohibitSet |=> !linkProhibitFlag)
    else $error("prohibit not cleared");
  chk_sticky_set: assert property (
    linkDone && linkErr != 5'h00 && cfgPort == 2'h1 |=> linkErrorStickyFlag)
    else $error("sticky flag missed error");
  chk_sticky_hold: assert property (
    linkErrorStickyFlag && !stickyClear |=> linkErrorStickyFlag)
    else $error("sticky flag dropped");
  chk_poll_range: assert property (
    cfgSlaveCount != 5'h00 |-> pollStation != 5'h00
      && pollStation <= cfgSlaveCount) else $error("poll out of range");
  chk_retry_mark: assert property (
    errRdata != 7'h00 |-> errRdata[5]) else $error("code lacks retry bit");
  chk_header_station: assert property (
    cfgMaster && $rose(txValid) |-> txData[4:0] == pollStation)
    else $error("header names wrong station");
  chk_master_no_stop: assert property (
    cfgMaster |-> !linkInitOrStopFlag) else $error("stop flag on master");
  cover property (linkDone && linkErr != 5'h00);
  cover property ($rose(linkProhibitFlag));
  cover property (txValid && txReady && txLast);
endmodule // pdl_station_monitor
bind pdl_station pdl_station_monitor #(.STOP_CYCLES(STOP_CYCLES))
  i_pdl_station_monitor (.clk_sys, .reset, .cfgMaster, .cfgPort,
  .cfgSlaveCount, .prohibitSet, .prohibitClear, .stickyClear, .errRdata,
  .txValid, .txReady, .txData, .txLast, .linkDone, .linkErr, .pollStation,
  .linkErrorStickyFlag, .linkProhibitFlag, .linkInitOrStopFlag);

//--- verif/tb_polled_station_data_link.sv
// Testbench: one station in master mode with two slaves served by the peer, then restarted as a slave.
// Assumes the peer answers every poll and the checker is bound.
`include "pdl_map.vh"
module tb_polled_station_data_link;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_sys, reset, cfgMaster, prohibitRetained, prohibitSet;
  logic        prohibitClear, stickyClear, errClear, hostWrite, txValid;
  logic        txReady, txLast, rxValid, rxReady, linkDone;
  logic        linkErrorStickyFlag, linkProhibitFlag, linkInitOrStopFlag;
  logic [1:0]  cfgPort;
  logic [2:0]  cfgWordCount;
  logic [4:0]  cfgSlaveCount, cfgStationNo, errAddr, linkErr, pollStation;
  logic [4:0]  failBits, hdrSt;
  logic [6:0]  errRdata;
  logic [7:0]  doneCnt;
  logic [8:0]  cfgAltErrIndex, hostAddr;
  logic [15:0] hostWdata, hostRdata, txData, rxData, txW0;
  int          fail_count, num_checks, s, k;
  pdl_station #(.STOP_CYCLES(50)) i_pdl_station (.clk_sys, .reset,
    .cfgMaster, .cfgPort, .cfgWordCount, .cfgSlaveCount, .cfgStationNo,
    .cfgAltErrIndex, .prohibitRetained, .prohibitSet, .prohibitClear,
    .stickyClear, .errClear, .errAddr, .errRdata, .hostAddr, .hostWrite,
    .hostWdata, .hostRdata, .txValid, .txReady, .txData, .txLast, .rxValid,
    .rxReady, .rxData, .linkDone, .linkErr, .pollStation,
    .linkErrorStickyFlag, .linkProhibitFlag, .linkInitOrStopFlag);
  pdl_link_peer i_pdl_link_peer (.clk_sys, .txValid, .txData, .txLast,
    .txReady, .rxValid, .rxData, .rxReady, .linkDone, .linkErr,
    .nWords(cfgWordCount), .failBits, .doneCnt, .hdrSt, .txW0);
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [8:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    {hostAddr, hostWdata, hostWrite} <= {a, d, 1'b1};
    @(posedge clk_sys);
    hostWrite <= 1'b0;
  endtask
  task automatic rd(input logic [8:0] a, input logic [15:0] e);
    @(posedge clk_sys);
    hostAddr <= a;
    @(posedge clk_sys);
    #1 chk(hostRdata, e);
  endtask
  // Bounded wait for n more completed attempts at the peer
  task automatic wait_done(input int n);
    int t;
    t = doneCnt + n;
    for (int i = 0; i < 3000 && doneCnt < t; i++) @(posedge clk_sys);
    chk(16'(doneCnt >= t), 16'h0001);
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  initial begin
    #500000;
    fail_count++;
    give_verdict();
  end
  initial begin
    {reset, prohibitRetained, cfgMaster, cfgPort} = 5'h1d;
    {prohibitSet, prohibitClear, stickyClear, errClear, hostWrite} = '0;
    {cfgWordCount, cfgSlaveCount, cfgStationNo} = {3'h2, 5'h02, 5'h00};
    {cfgAltErrIndex, hostAddr, hostWdata, errAddr, failBits} = '0;
    {fail_count, num_checks} = '0;
    repeat (20) @(posedge clk_sys);
    reset <= 1'b0;
    repeat (30) @(posedge clk_sys);
    chk(16'(linkProhibitFlag), 16'h0001);
    chk(16'(doneCnt), 16'h0000);
    for (s = 0; s < 3; s++)
      for (k = 0; k < 12; k++)
        wr(9'(s * 12 + k), k < 6 ? {8'h70, 3'(s), 5'(k)} : 16'h0000);
    @(posedge clk_sys) prohibitClear <= 1'b1;
    @(posedge clk_sys) prohibitClear <= 1'b0;
    wait_done(4);
    chk(txW0, {8'h70, 3'(hdrSt - 5'h01), 5'h00});
    for (s = 0; s < 2; s++)
      for (k = 0; k < 6; k++)
        rd(9'(s * 12 + 6 + k),
           k < 2 ? {3'h5, 5'(s + 1), 5'h00, 3'(k)} : 16'h0000);
    @(posedge clk_sys) prohibitSet <= 1'b1;
    @(posedge clk_sys) prohibitSet <= 1'b0;
    repeat (60) @(posedge clk_sys);
    k = doneCnt;
    repeat (80) @(posedge clk_sys);
    chk(16'(doneCnt), 16'(k));
    cfgWordCount <= 3'h6;
    @(posedge clk_sys) prohibitClear <= 1'b1;
    @(posedge clk_sys) prohibitClear <= 1'b0;
    wait_done(2);
    for (s = 0; s < 2; s++)
      rd(9'(s * 12 + 11), {3'h5, 5'(s + 1), 5'h00, 3'h5});
    // Two causes at once must be ORed with the retry mark
    failBits <= 5'h12;
    wait_done(3);
    failBits <= 5'h00;
    errAddr <= hdrSt - 5'h01;
    repeat (2) @(posedge clk_sys);
    #1 chk({9'h000, errRdata}, 16'h0032);
    chk(16'(linkErrorStickyFlag), 16'h0001);
    wait_done(2);
    chk(16'(linkErrorStickyFlag), 16'h0001);
    @(posedge clk_sys) {stickyClear, errClear} <= 2'h3;
    @(posedge clk_sys) {stickyClear, errClear} <= 2'h0;
    repeat (2) @(posedge clk_sys);
    #1 chk({9'h000, errRdata}, 16'h0000);
    chk(16'(linkErrorStickyFlag), 16'h0000);
    rd(9'h018, 16'h7040);
    rd(9'h01e, 16'h0000);
    // Alternate port: code lands in a data word, sticky flag stays off
    wait_done(1);
    {cfgPort, cfgAltErrIndex, failBits} <= {2'h2, 9'h0f0, 5'h01};
    wait_done(3);
    failBits <= 5'h00;
    rd(9'h0f0, 16'h0021);
    chk(16'(linkErrorStickyFlag), 16'h0000);
    // Quiet the master, then restart as a slave that hears nothing
    @(posedge clk_sys) prohibitSet <= 1'b1;
    @(posedge clk_sys) prohibitSet <= 1'b0;
    repeat (60) @(posedge clk_sys);
    {cfgMaster, reset} <= 2'h1;
    @(posedge clk_sys) reset <= 1'b0;
    repeat (40) @(posedge clk_sys);
    #1 chk(16'(linkInitOrStopFlag), 16'h0000);
    repeat (15) @(posedge clk_sys);
    #1 chk(16'(linkInitOrStopFlag), 16'h0001);
    give_verdict();
  end
endmodule // tb_polled_station_data_link
